// File: pkg/kars_pkg.sv
/*
 * kars_pkg: constants and carrier types for the keypad autorepeat,
 * sleep and two-wire slave control slice.
 * assumes: a 125 MHz core clock and a debounce tick from outside.
 */
package kars_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_FIFO = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h01;
  localparam logic [7:0] REG_REPEAT = 8'h05;
  localparam logic [7:0] REG_SLEEP = 8'h06;
  localparam logic [7:0] RST_REPEAT = 8'h00;
  localparam logic [7:0] RST_SLEEP = 8'h07;
  localparam logic [7:0] RST_CONFIG = 8'h8a;
  localparam int CFG_AWAKE_BIT = 7;
  localparam int CFG_AUTOWAKE_BIT = 1;
  localparam int REP_EN_BIT = 7;
  localparam logic [7:0] REPEAT_CODE = 8'h7e;
  localparam logic [3:0] ADDR_HIGH = 4'h7;
  localparam logic [7:0] DELAY_STEP = 8'h08;
  localparam logic [7:0] RATE_STEP = 8'h04;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int WAKE_MS = 2;
  localparam int WAKE_CYC = WAKE_MS * 1000 * CLK_MHZ;
  localparam int MS_CYC = 1000 * CLK_MHZ;
  localparam int SLEEP_MAX_MS = 8192;
  localparam logic [2:0] SLEEP_CODE_MIN = 3'h6;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } kars_fifo_wr_t;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_ACK = 3'b010,
    BUS_RX = 3'b011,
    BUS_TX = 3'b100,
    BUS_MACK = 3'b101
  } kars_bus_t;
endpackage : kars_pkg

// File: core/kars_sync.sv
/*
 * kars_sync: two-flop synchroniser for a group of pin levels.
 * assumes: inputs asynchronous to CLK_I.
 */
`timescale 1ns/10ps
module kars_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta <= '1;
      q_o <= '1;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : kars_sync

// File: core/kars_top.sv
/*
 * kars_top: autorepeat, autosleep/wake and two-wire slave registers.
 * assumes: debounce engine supplies tick, press/release events and a
 * held level on the same clock; FIFO storage sits outside and keeps
 * its data whatever the sleep state.
 */
`timescale 1ns/10ps
module kars_top (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // two-wire bus
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N_O,
  // address strap, 0 gnd 1 vcc 2 sda 3 scl
  input wire logic [1:0] ADDRESS_STRAP_PIN_I,
  // debounce engine
  input wire logic DEB_TICK_I,
  input wire logic KEY_EVENT_I,
  input wire logic KEY_RELEASE_I,
  input wire logic KEY_HELD_I,
  // fifo
  output kars_pkg::kars_fifo_wr_t FIFO_WR_O,
  input wire logic [7:0] FIFO_RD_DATA_I,
  output logic FIFO_RD_O,
  // sleep control
  output logic SLEEP_O,
  output logic WAKE_READY_O
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic scl;
  logic sda;
  logic scl_d;
  logic sda_d;
  kars_sync #(.W(2)) u_sync (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .d_i({SCL_I, SDA_I}),
    .q_o({scl, sda})
  );
  // strap may follow sda or scl, so it is a pin like them
  logic [1:0] strap;
  kars_sync #(.W(2)) u_strap_sync (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .d_i(ADDRESS_STRAP_PIN_I),
    .q_o(strap)
  );
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  assign start_det = scl && scl_d && sda_d && !sda;
  assign stop_det = scl && scl_d && !sda_d && sda;
  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] repeat_ctl;
  logic [7:0] sleep_ctl;
  logic [7:0] config_reg;
  logic [7:0] pointer;
  logic wr_stb;
  logic [7:0] wr_data;
  logic ptr_load;
  logic ptr_adv;
  logic [7:0] my_addr;
  logic [7:0] rd_data;
  logic asleep;
  // strap picks a3..a2, a1 is always zero, a0 is the direction slot
  assign my_addr = {kars_pkg::ADDR_HIGH, strap,
                    1'b0, 1'b0};
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      repeat_ctl <= kars_pkg::RST_REPEAT;
      sleep_ctl <= kars_pkg::RST_SLEEP;
      config_reg <= kars_pkg::RST_CONFIG;
    end else if (wr_stb) begin
      case (pointer)
        kars_pkg::REG_REPEAT: repeat_ctl <= wr_data;
        kars_pkg::REG_SLEEP: sleep_ctl <= wr_data;
        kars_pkg::REG_CONFIG: config_reg <= wr_data;
        default: ;
      endcase
    end
  end
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      pointer <= kars_pkg::REG_FIFO;
    end else if (ptr_load) begin
      pointer <= wr_data;
    end else if (ptr_adv) begin
      if (pointer == kars_pkg::REG_SLEEP) begin
        pointer <= kars_pkg::REG_FIFO;
      end else if (pointer != kars_pkg::REG_FIFO) begin
        pointer <= pointer + 8'h01;
      end
    end
  end
  always_comb begin
    case (pointer)
      kars_pkg::REG_FIFO: rd_data = FIFO_RD_DATA_I;
      kars_pkg::REG_CONFIG: rd_data = {!asleep, config_reg[6:0]};
      kars_pkg::REG_REPEAT: rd_data = repeat_ctl;
      kars_pkg::REG_SLEEP: rd_data = sleep_ctl;
      default: rd_data = 8'h00;
    endcase
  end

  // ****************************************
  // two-wire slave
  // ****************************************
  kars_pkg::kars_bus_t state;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic rw;
  logic got_reg;
  // byte completes on the falling clock edge after the eighth rising edge
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      state <= kars_pkg::BUS_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      rw <= 1'b0;
      got_reg <= 1'b0;
      SDA_O <= 1'b1;
      SDA_OE_N_O <= 1'b1;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
      ptr_load <= 1'b0;
      ptr_adv <= 1'b0;
      FIFO_RD_O <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      ptr_load <= 1'b0;
      ptr_adv <= 1'b0;
      FIFO_RD_O <= 1'b0;
      if (start_det) begin
        state <= kars_pkg::BUS_ADDR;
        bitcnt <= 4'h0;
        got_reg <= 1'b0;
        SDA_OE_N_O <= 1'b1;
      end else if (stop_det) begin
        state <= kars_pkg::BUS_IDLE;
        SDA_OE_N_O <= 1'b1;
      end else begin
        case (state)
          kars_pkg::BUS_IDLE: SDA_OE_N_O <= 1'b1;
          kars_pkg::BUS_ADDR, kars_pkg::BUS_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              if (state == kars_pkg::BUS_ADDR) begin
                if (shreg[7:1] == my_addr[7:1]) begin
                  rw <= shreg[0];
                  state <= kars_pkg::BUS_ACK;
                  SDA_O <= 1'b0;
                  SDA_OE_N_O <= 1'b0;
                end else begin
                  state <= kars_pkg::BUS_IDLE;
                end
              end else begin
                state <= kars_pkg::BUS_ACK;
                SDA_O <= 1'b0;
                SDA_OE_N_O <= 1'b0;
                wr_data <= shreg;
                got_reg <= 1'b1;
                ptr_load <= !got_reg;
                wr_stb <= got_reg;
                ptr_adv <= got_reg;
              end
            end
          end
          kars_pkg::BUS_ACK: begin
            if (scl_fall) begin
              if (rw) begin
                state <= kars_pkg::BUS_TX;
                shreg <= {rd_data[6:0], 1'b0};
                bitcnt <= 4'h1;
                SDA_O <= 1'b0;
                SDA_OE_N_O <= rd_data[7];
                FIFO_RD_O <= (pointer == kars_pkg::REG_FIFO);
                ptr_adv <= 1'b1;
              end else begin
                state <= kars_pkg::BUS_RX;
                SDA_OE_N_O <= 1'b1;
              end
            end
          end
          kars_pkg::BUS_TX: begin
            if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                state <= kars_pkg::BUS_MACK;
                SDA_OE_N_O <= 1'b1;
              end else begin
                SDA_OE_N_O <= shreg[7];
                shreg <= {shreg[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          kars_pkg::BUS_MACK: begin
            if (scl_rise) begin
              // master nack ends the read
              state <= sda ? kars_pkg::BUS_IDLE : kars_pkg::BUS_ACK;
            end
          end
          default: state <= kars_pkg::BUS_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // autorepeat
  // ****************************************
  logic [7:0] rep_cnt;
  logic rep_first;
  logic [7:0] rep_limit;
  assign rep_limit = rep_first
    ? 8'((repeat_ctl[3:0] + 8'h01) * kars_pkg::DELAY_STEP)
    : 8'((repeat_ctl[6:4] + 8'h01) * kars_pkg::RATE_STEP);
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      rep_cnt <= 8'h00;
      rep_first <= 1'b1;
      FIFO_WR_O <= '0;
    end else begin
      FIFO_WR_O.valid <= 1'b0;
      if (KEY_EVENT_I || KEY_RELEASE_I || asleep
          || !repeat_ctl[kars_pkg::REP_EN_BIT] || !KEY_HELD_I) begin
        rep_cnt <= 8'h00;
        rep_first <= 1'b1;
      end else if (DEB_TICK_I) begin
        if (rep_cnt + 8'h01 >= rep_limit) begin
          rep_cnt <= 8'h00;
          rep_first <= 1'b0;
          FIFO_WR_O.valid <= 1'b1;
          FIFO_WR_O.data <= kars_pkg::REPEAT_CODE;
        end else begin
          rep_cnt <= rep_cnt + 8'h01;
        end
      end
    end
  end

  // ****************************************
  // sleep and wake
  // ****************************************
  logic [13:0] ms_left;
  logic [16:0] ms_pre;
  logic [17:0] wake_cnt;
  logic [13:0] timeout_ms;
  logic [2:0] code;
  assign code = (sleep_ctl[2:0] > kars_pkg::SLEEP_CODE_MIN)
    ? kars_pkg::SLEEP_CODE_MIN : sleep_ctl[2:0];
  assign timeout_ms = 14'(kars_pkg::SLEEP_MAX_MS >> (code - 3'h1));
  assign asleep = SLEEP_O;
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      SLEEP_O <= 1'b0;
      ms_left <= 14'h0;
      ms_pre <= 17'h0;
    end else if (wr_stb && pointer == kars_pkg::REG_CONFIG) begin
      SLEEP_O <= !wr_data[kars_pkg::CFG_AWAKE_BIT];
      ms_left <= timeout_ms;
      ms_pre <= 17'h0;
    end else if (SLEEP_O) begin
      // fifo storage is never touched here
      if (KEY_HELD_I && config_reg[kars_pkg::CFG_AUTOWAKE_BIT]) begin
        SLEEP_O <= 1'b0;
        ms_left <= timeout_ms;
      end
    end else if (KEY_HELD_I || KEY_EVENT_I || sleep_ctl[2:0] == 3'h0) begin
      ms_left <= timeout_ms;
      ms_pre <= 17'h0;
    end else if (ms_pre == 17'(kars_pkg::MS_CYC - 1)) begin
      ms_pre <= 17'h0;
      if (ms_left <= 14'h1) begin
        SLEEP_O <= 1'b1;
      end else begin
        ms_left <= ms_left - 14'h1;
      end
    end else begin
      ms_pre <= ms_pre + 17'h1;
    end
  end
  // debounce engine holds off until start-up elapses
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      wake_cnt <= 18'h0;
      WAKE_READY_O <= 1'b1;
    end else if (SLEEP_O) begin
      wake_cnt <= 18'h0;
      WAKE_READY_O <= 1'b0;
    end else if (!WAKE_READY_O) begin
      if (wake_cnt == 18'(kars_pkg::WAKE_CYC - 1)) begin
        WAKE_READY_O <= 1'b1;
      end else begin
        wake_cnt <= wake_cnt + 18'h1;
      end
    end
  end
endmodule : kars_top

// File: testbench/kars_top_monitor.sv
/* kars_top_monitor: port checks for kars_top, bound at the foot.
   assumes: one clock domain, synchronous active-low reset. */
`timescale 1ns/10ps
module kars_top_monitor (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // bus
  input wire logic SCL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_N_O,
  // keys, fifo, sleep
  input wire logic KEY_EVENT_I,
  input wire logic KEY_HELD_I,
  input kars_pkg::kars_fifo_wr_t FIFO_WR_O,
  input wire logic FIFO_RD_O,
  input wire logic SLEEP_O,
  input wire logic WAKE_READY_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  // ********
  // checks
  // ********
  a_sda_pulls_low: assert property (
    !SDA_OE_N_O |-> !SDA_O) else $error("sda driven high");
  // sync delay puts every change a few cycles into the low phase
  a_sda_moves_low: assert property (
    $changed(SDA_OE_N_O) |-> !SCL_I || !$past(SCL_I))
    else $error("sda moved with scl high");
  a_repeat_code: assert property (
    FIFO_WR_O.valid |-> FIFO_WR_O.data == 8'h7e) else $error("bad code");
  a_one_code: assert property (
    FIFO_WR_O.valid |=> !FIFO_WR_O.valid) else $error("code doubled");
  a_repeat_held: assert property (
    FIFO_WR_O.valid |-> KEY_HELD_I || $past(KEY_HELD_I)
      || $past(KEY_HELD_I, 2)) else $error("repeat with no key");
  a_event_restart: assert property (
    KEY_EVENT_I |-> ##2 !FIFO_WR_O.valid [*6])
    else $error("repeat right after event");
  a_sleep_keeps: assert property (
    SLEEP_O && $past(SLEEP_O) |-> !FIFO_WR_O.valid)
    else $error("fifo written asleep");
  a_wake_startup: assert property (
    $fell(SLEEP_O) && KEY_HELD_I |-> ##1 !WAKE_READY_O [*8])
    else $error("no start-up wait");
  a_pop_once: assert property (
    FIFO_RD_O |=> !FIFO_RD_O [*8]) else $error("fifo popped twice");
  c_repeat: cover property (FIFO_WR_O.valid);
  c_wake: cover property ($fell(SLEEP_O));
  c_ack: cover property ($fell(SDA_OE_N_O));
  c_pop: cover property (FIFO_RD_O);
endmodule : kars_top_monitor

bind kars_top kars_top_monitor u_mon (.CLK_I, .RESET_N_I, .SCL_I, .SDA_O,
  .SDA_OE_N_O, .KEY_EVENT_I, .KEY_HELD_I, .FIFO_WR_O, .FIFO_RD_O,
  .SLEEP_O, .WAKE_READY_O);

// File: testbench/kars_i2c_master.sv
/* kars_i2c_master: behavioural bus master, 80 ns link period.
   assumes: the bench resolves the open-drain data line. */
`timescale 1ns/10ps
module kars_i2c_master (
  // bus lines, 1 = released
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  localparam int Q = 20;
  // ********
  // bus cycles
  // ********
  initial begin
    scl_o = 1'b1; // only we clock; idle high
    sda_o = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask : bit_io
  task automatic start;
    sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
    #Q;
  endtask : start
  task automatic stop;
    sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #(2 * Q);
  endtask : stop
  // msb first, ninth clock acknowledges
  task automatic xbyte(input logic [7:0] d, input logic mack,
    output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(mack, ack);
  endtask : xbyte
endmodule : kars_i2c_master

// File: testbench/kars_top_tb_top.sv
/* kars_top_tb_top: self-checking bench for kars_top.
   assumes: kars_i2c_master plays the bus host. */
`timescale 1ns/10ps
`define CHK(n, e, a) begin n_tests++; if ((e) !== (a)) begin \
  n_errors++; $display("mismatch %s exp %h got %h", n, e, a); end end
module kars_top_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, held = 1'b0;
  logic ev = 1'b0, rel = 1'b0, sda_o, sda_oe_n, rd_pop, sleep, wake_rdy;
  logic m_scl, m_sda;
  logic [6:0] addr;
  logic [7:0] head;
  kars_pkg::kars_fifo_wr_t fifo_wr;
  wire sda = m_sda & (sda_oe_n | sda_o);
  int seed = 32'h7dfece9b, n_errors = 0, n_tests = 0, cyc = 0;
  int ticks = 0, n_pop = 0, gap_exp;
  int exp_q[$];
  always #4 clk = ~clk;
  kars_i2c_master m (.scl_o(m_scl), .sda_o(m_sda), .sda_i(sda));
  kars_top dut (.CLK_I(clk), .RESET_N_I(rst_n), .SCL_I(m_scl),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n),
    .ADDRESS_STRAP_PIN_I(addr[2:1]), .DEB_TICK_I(tick), .KEY_EVENT_I(ev),
    .KEY_RELEASE_I(rel), .KEY_HELD_I(held), .FIFO_WR_O(fifo_wr),
    .FIFO_RD_DATA_I(head), .FIFO_RD_O(rd_pop), .SLEEP_O(sleep),
    .WAKE_READY_O(wake_rdy));
  // ********
  // tasks
  // ********
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // event lands just after a tick so no count is split
  task automatic key(input logic h, input logic r);
    @(negedge clk iff tick);
    held = h;
    rel = r;
    ev = 1'b1;
    @(negedge clk);
    ev = 1'b0;
    rel = 1'b0;
  endtask : key
  task automatic wait_q;
    for (int k = 0; k < 3000 && exp_q.size() != 0; k++) @(posedge clk);
    `CHK("repeats seen", 0, exp_q.size())
  endtask : wait_q
  task automatic wr(input logic [7:0] p, d, input logic full);
    logic [7:0] q;
    logic a;
    m.start();
    m.xbyte({addr, 1'b0}, 1'b1, q, a); // low bit asks to write
    `CHK("addr ack", 1'b0, a)
    m.xbyte(p, 1'b1, q, a);
    `CHK("ptr ack", 1'b0, a)
    if (full) m.xbyte(d, 1'b1, q, a);
    m.stop();
  endtask : wr
  task automatic rd2(input logic [7:0] p, e0, e1);
    logic [7:0] q;
    logic a;
    wr(p, 8'h00, 1'b0);
    m.start();
    m.xbyte({addr, 1'b1}, 1'b1, q, a);
    `CHK("read ack", 1'b0, a)
    m.xbyte(8'hff, 1'b0, q, a);
    `CHK("byte 0", e0, q)
    m.xbyte(8'hff, 1'b1, q, a);
    `CHK("byte 1", e1, q)
    m.stop();
  endtask : rd2
  // ********
  // result side and timeout
  // ********
  always @(posedge clk) begin
    cyc++;
    if (rd_pop === 1'b1) n_pop++;
    if (fifo_wr.valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK("spare repeat", 1'b0, 1'b1)
      else begin
        gap_exp = exp_q.pop_front();
        `CHK("repeat gap", gap_exp, ticks)
      end
      `CHK("code", kars_pkg::REPEAT_CODE, fifo_wr.data)
      ticks <= 0;
    end else if (ev) ticks <= 0;
    else if (tick) ticks <= ticks + 1;
    if (cyc == 60000) begin
      n_errors++;
      print_verdict();
    end
  end
  always @(negedge clk) tick <= (cyc % 8 == 0);
  // ********
  // main sequence
  // ********
  initial begin
    logic [7:0] q, rep;
    logic a;
    int rv, dly, gap;
    rv = $random(seed);
    addr = {4'b0111, rv[1:0], 1'b0}; // strap sets two bits
    head = rv[15:8];
    repeat (8) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (3) @(posedge clk);
    rd2(kars_pkg::REG_REPEAT, 8'h00, 8'h07);
    rd2(kars_pkg::REG_SLEEP, 8'h07, head);
    rd2(kars_pkg::REG_FIFO, head, head);
    rd2(kars_pkg::REG_CONFIG, 8'h8a, 8'h00);
    `CHK("fifo pops", 3, n_pop)
    m.start();
    m.xbyte({addr ^ 7'h04, 1'b0}, 1'b1, q, a);
    m.stop();
    `CHK("foreign nack", 1'b1, a)
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      rv = $random(seed);
      rep = i ? 8'hff : {1'b1, rv[6:0]};
      wr(kars_pkg::REG_REPEAT, rep, 1'b1);
      dly = (int'(rep[3:0]) + 1) * 8;
      gap = (int'(rep[6:4]) + 1) * 4;
      exp_q = {dly, gap, gap};
      key(1'b1, 1'b0);
      wait_q();
      exp_q = {dly, gap}; // release with keys left restarts
      key(1'b1, 1'b1);
      wait_q();
      key(1'b0, 1'b1);
      repeat (1200) @(posedge clk);
      $display("test repeat %0d done", i);
    end
    wr(kars_pkg::REG_REPEAT, 8'h00, 1'b1);
    wr(kars_pkg::REG_CONFIG, 8'h0a, 1'b1);
    `CHK("sleep", 1'b1, sleep)
    rd2(kars_pkg::REG_CONFIG, 8'h0a, 8'h00);
    key(1'b1, 1'b0);
    for (int k = 0; k < 100 && sleep !== 1'b0; k++) @(posedge clk);
    `CHK("autowake", 1'b0, sleep)
    `CHK("start-up", 1'b0, wake_rdy)
    key(1'b0, 1'b1);
    wr(kars_pkg::REG_CONFIG, 8'h08, 1'b1);
    key(1'b1, 1'b0);
    repeat (100) @(posedge clk);
    `CHK("no autowake", 1'b1, sleep)
    key(1'b0, 1'b1);
    wr(kars_pkg::REG_CONFIG, 8'h88, 1'b1);
    `CHK("wake", 1'b0, sleep)
    rd2(kars_pkg::REG_CONFIG, 8'h88, 8'h00);
    `CHK("fifo kept", 3, n_pop)
    $display("test sleep done");
    print_verdict();
  end
endmodule : kars_top_tb_top
